// ### hdl/sram_host_ctrl.sv
// Host controller driving an asynchronous 512K x 8 static RAM
// How it works
// (R01) 512K bytes, 19-bit address, one byte per access on shared data lines.
// (R02) Write stores bus byte when select and write strobe are both low.
// (R03) Read drives data when select and output enable low, write strobe high.
// (R04) Device floats data when deselected, output disabled or writing.
// (R05) Select high means power-down; host keeps select high while idle.
// (R06) Read data valid 70/85 ns after address settles.
// (R07) Old read data held at least 10 ns after address change.
// (R08) Read data valid 70/85 ns after select falls.
// (R09) Read data valid 35/45 ns after output enable falls.
// (R10) Outputs float within 25/30 ns after output enable or select rises.
// (R11) Outputs float within 25/30 ns after write strobe falls.
// (R12) Write happens only while select and write strobe overlap low.
// (R13) Address stable at least 60/75 ns before write end.
// (R14) Address present no later than write start.
// (R15) Address unchanged until write has ended.
// (R16) Write data valid 30/35 ns before write end, held to end.
// (R17) Data setup and hold timed against the terminating rising edge.
// (R18) Select and write strobe rising together leaves outputs floating.
// (R19) Address valid no later than select falling for a read.
// (R20) Unwritten memory contents are undefined.
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl #(
   parameter bit FAST_GRADE = 1'b0
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // User request
   input wire logic req_i,
   input wire logic wr_i,
   input wire logic [sram_host_pkg::ADDR_W-1:0] addr_i,
   input wire logic [sram_host_pkg::DATA_W-1:0] wdata_i,
   output logic ready_o,
   // User read answer
   output logic rvalid_o,
   output logic [sram_host_pkg::DATA_W-1:0] rdata_o,
   // Memory pins
   output logic [sram_host_pkg::ADDR_W-1:0] mem_addr_o,
   output logic mem_sel_n_o,
   output logic mem_wr_n_o,
   output logic mem_oe_n_o,
   output logic [sram_host_pkg::DATA_W-1:0] mem_data_o,
   output logic mem_data_oe_o,
   input wire logic [sram_host_pkg::DATA_W-1:0] mem_data_i
);

   // ==========================================================
   // Cycle counts for the chosen grade
   localparam int RD_CYC = FAST_GRADE ? sram_host_pkg::RD_CYC_FAST : sram_host_pkg::RD_CYC_SLOW;
   localparam int WR_CYC = FAST_GRADE ? sram_host_pkg::WR_CYC_FAST : sram_host_pkg::WR_CYC_SLOW;
   localparam int TURN_CYC = FAST_GRADE ? sram_host_pkg::TURN_CYC_FAST : sram_host_pkg::TURN_CYC_SLOW;
   localparam logic [sram_host_pkg::CNT_W-1:0] RD_LOAD = sram_host_pkg::CNT_W'(RD_CYC - 1);
   localparam logic [sram_host_pkg::CNT_W-1:0] WR_LOAD = sram_host_pkg::CNT_W'(WR_CYC - 1);
   localparam logic [sram_host_pkg::CNT_W-1:0] TURN_LOAD = sram_host_pkg::CNT_W'(TURN_CYC - 1);

   // ==========================================================
   // Declarations
   sram_host_pkg::ctrl_state_e state_reg;
   sram_host_pkg::ctrl_state_e state_next;
   logic [sram_host_pkg::CNT_W-1:0] cnt_reg;
   logic [sram_host_pkg::CNT_W-1:0] cnt_next;
   logic [sram_host_pkg::ADDR_W-1:0] addr_reg;
   logic [sram_host_pkg::DATA_W-1:0] wdata_reg;
   logic [sram_host_pkg::DATA_W-1:0] rdata_reg;
   logic [sram_host_pkg::DATA_W-1:0] rd_sync;
   logic sel_n_reg;
   logic wr_n_reg;
   logic oe_n_reg;
   logic data_oe_reg;
   logic ready_reg;
   logic rvalid_reg;
   wire cnt_done;
   wire take_req;
   wire take_wr;
   wire take_rd;

   // ==========================================================
   // Read data synchroniser
   sram_pin_sync #(
      .WIDTH(sram_host_pkg::DATA_W)
   ) u_rd_sync (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .async_i(mem_data_i),
      .sync_o(rd_sync)
   );

   // ==========================================================
   // Decode
   assign cnt_done = (cnt_reg == '0);
   assign take_req = req_i && ready_reg;
   assign take_wr = take_req && wr_i;
   assign take_rd = take_req && !wr_i;

   // ==========================================================
   // Next state
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         sram_host_pkg::ST_IDLE: begin
            if (take_wr) begin
               state_next = sram_host_pkg::ST_WRITE;
               cnt_next = WR_LOAD; // R13
            end else if (take_rd) begin
               state_next = sram_host_pkg::ST_READ;
               cnt_next = RD_LOAD; // R06
            end
         end
         sram_host_pkg::ST_WRITE: begin
            if (cnt_done) begin
               state_next = sram_host_pkg::ST_WHOLD;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         sram_host_pkg::ST_WHOLD: begin
            state_next = sram_host_pkg::ST_TURN;
            cnt_next = TURN_LOAD;
         end
         sram_host_pkg::ST_READ: begin
            if (cnt_done) begin
               state_next = sram_host_pkg::ST_TURN;
               cnt_next = TURN_LOAD; // R10
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         sram_host_pkg::ST_TURN: begin
            if (cnt_done) begin
               state_next = sram_host_pkg::ST_IDLE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         default: begin
            state_next = sram_host_pkg::ST_IDLE;
            cnt_next = '0;
         end
      endcase
   end

   // ==========================================================
   // State and counter
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= sram_host_pkg::ST_IDLE;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // ==========================================================
   // Address and write data, loaded only at request
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         addr_reg <= sram_host_pkg::ADDR_RST;
         wdata_reg <= sram_host_pkg::DATA_RST;
      end else if (take_req) begin
         addr_reg <= addr_i; // R01 R14 R15 R19
         wdata_reg <= wdata_i; // R16
      end
   end

   // ==========================================================
   // Strobes
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sel_n_reg <= 1'b1; // R05
         wr_n_reg <= 1'b1;
         oe_n_reg <= 1'b1;
      end else if (take_wr) begin
         sel_n_reg <= 1'b0; // R02 R12
         wr_n_reg <= 1'b0; // R11
         oe_n_reg <= 1'b1;
      end else if (take_rd) begin
         sel_n_reg <= 1'b0; // R08 R19
         wr_n_reg <= 1'b1; // R03
         oe_n_reg <= 1'b0; // R09
      end else if ((state_reg == sram_host_pkg::ST_WRITE || state_reg == sram_host_pkg::ST_READ) && cnt_done) begin
         sel_n_reg <= 1'b1; // R12 R17 R18
         wr_n_reg <= 1'b1; // R18
         oe_n_reg <= 1'b1; // R10
      end
   end

   // ==========================================================
   // Data bus drive, kept one cycle past write end
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         data_oe_reg <= 1'b0;
      end else if (take_wr) begin
         data_oe_reg <= 1'b1; // R04 R16
      end else if (state_reg == sram_host_pkg::ST_WHOLD) begin
         data_oe_reg <= 1'b0; // R17
      end
   end

   // ==========================================================
   // User side
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= sram_host_pkg::DATA_RST;
      end else begin
         ready_reg <= (state_next == sram_host_pkg::ST_IDLE);
         rvalid_reg <= (state_reg == sram_host_pkg::ST_READ) && cnt_done;
         if ((state_reg == sram_host_pkg::ST_READ) && cnt_done) begin
            rdata_reg <= rd_sync; // R06 R08 R20
         end
      end
   end

   // ==========================================================
   // Outputs
   assign ready_o = ready_reg;
   assign rvalid_o = rvalid_reg;
   assign rdata_o = rdata_reg;
   assign mem_addr_o = addr_reg;
   assign mem_sel_n_o = sel_n_reg;
   assign mem_wr_n_o = wr_n_reg;
   assign mem_oe_n_o = oe_n_reg;
   assign mem_data_o = wdata_reg;
   assign mem_data_oe_o = data_oe_reg;

endmodule
`default_nettype wire

// ### inc/sram_host_pkg.sv
// Timing, width and state constants for the static RAM host controller
package sram_host_pkg;

   // ==========================================================
   // Widths
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int CNT_W = 6;

   // ==========================================================
   // Clock
   localparam int CLK_PERIOD_NS = 4;

   // ==========================================================
   // Device timing in ns, fast grade then slow grade
   localparam int T_AA_FAST_NS = 70;
   localparam int T_AA_SLOW_NS = 85;
   localparam int T_SCE_FAST_NS = 60;
   localparam int T_SCE_SLOW_NS = 75;
   localparam int T_HZ_FAST_NS = 25;
   localparam int T_HZ_SLOW_NS = 30;
   localparam int T_SD_FAST_NS = 30;
   localparam int T_SD_SLOW_NS = 35;

   // ==========================================================
   // Cycle counts, least times rounded up, with the synchroniser stages added to reads
   localparam int SYNC_STAGES = 2;
   localparam int RD_CYC_FAST = (T_AA_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
   localparam int RD_CYC_SLOW = (T_AA_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
   localparam int WR_CYC_FAST = (T_SCE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_CYC_SLOW = (T_SCE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TURN_CYC_FAST = (T_HZ_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TURN_CYC_SLOW = (T_HZ_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Reset values
   localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

   // ==========================================================
   // Controller states
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_WRITE = 5'h02,
      ST_WHOLD = 5'h04,
      ST_READ  = 5'h08,
      ST_TURN  = 5'h10
   } ctrl_state_e;

endpackage

// ### hdl/sram_pin_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sram_pin_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Data
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   // ==========================================================
   // Stages
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= async_i;
         stage2_reg <= stage1_reg;
      end
   end

   assign sync_o = stage2_reg;

endmodule
`default_nettype wire

// ### dv/sram_model.sv
// Behavioural model of the 512K x 8 static RAM
`timescale 1ns/1ps
`default_nettype none
module sram_model #(
   parameter int ACC_NS = 85,
   parameter int HOLD_NS = 10
) (
   // Pins in
   input wire logic [18:0] addr_i,
   input wire logic sel_n_i,
   input wire logic wr_n_i,
   input wire logic oe_n_i,
   input wire logic [7:0] dq_i,
   // Pins out
   output logic [7:0] dq_o,
   output logic dq_oe_o
);
   logic [7:0] mem [logic [18:0]];
   realtime t_chg = 0;
   initial dq_o = 8'h00;
   always @(addr_i or sel_n_i or oe_n_i) t_chg = $realtime;
   always #1 begin
      if (!sel_n_i && !wr_n_i) mem[addr_i] = dq_i;
      dq_oe_o = !sel_n_i && !oe_n_i && wr_n_i;
      if (dq_oe_o && !mem.exists(addr_i)) dq_o = 8'hxx;
      else if (dq_oe_o && $realtime - t_chg >= ACC_NS) dq_o = mem[addr_i];
      else if ($realtime - t_chg >= HOLD_NS) dq_o = ~dq_o;
   end
endmodule
`default_nettype wire

// ### dv/sram_host_ctrl_chk.sv
// Pin protocol checker for the static RAM host controller
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl_chk #(
   parameter bit FAST_GRADE = 1'b0
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Watched ports
   input wire logic ready_o,
   input wire logic rvalid_o,
   input wire logic [18:0] mem_addr_o,
   input wire logic mem_sel_n_o,
   input wire logic mem_wr_n_o,
   input wire logic mem_oe_n_o,
   input wire logic [7:0] mem_data_o,
   input wire logic mem_data_oe_o
);
   localparam int WR = FAST_GRADE ? 15 : 19;
   localparam int RD = FAST_GRADE ? 20 : 24;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   idle_sel_a: assert property (ready_o |-> mem_sel_n_o) else $error("select low while idle");
   wr_strobe_a: assert property (!mem_wr_n_o |-> !mem_sel_n_o && mem_oe_n_o && mem_data_oe_o)
      else $error("bad write strobes");
   rd_drive_a: assert property (!mem_oe_n_o |-> !mem_data_oe_o && mem_wr_n_o) else $error("bus contention");
   rise_together_a: assert property ($rose(mem_wr_n_o) |-> $rose(mem_sel_n_o)) else $error("strobes split");
   addr_change_a: assert property ($changed(mem_addr_o) |-> $fell(mem_sel_n_o)) else $error("address moved");
   wdata_stable_a: assert property (!mem_wr_n_o && $past(!mem_wr_n_o) |-> $stable(mem_data_o))
      else $error("write data moved");
   wdata_hold_a: assert property ($rose(mem_wr_n_o) |-> mem_data_oe_o ##1 !mem_data_oe_o)
      else $error("write data hold");
   wr_len_a: assert property ($fell(mem_wr_n_o) |-> ##[WR:WR] $rose(mem_wr_n_o)) else $error("write length");
   rd_len_a: assert property ($fell(mem_oe_n_o) |-> ##[RD:RD] (rvalid_o && $rose(mem_oe_n_o)))
      else $error("read length");
   turn_gap_a: assert property ($rose(mem_sel_n_o) |-> !ready_o [*7]) else $error("turnaround short");
   wr_c: cover property ($rose(mem_wr_n_o));
   rd_c: cover property (rvalid_o);
   busy_c: cover property (!ready_o && $changed(mem_data_o));
endmodule
bind sram_host_ctrl sram_host_ctrl_chk #(.FAST_GRADE(FAST_GRADE)) chk (.mclk_i, .reset_n_i, .ready_o, .rvalid_o,
   .mem_addr_o, .mem_sel_n_o, .mem_wr_n_o, .mem_oe_n_o, .mem_data_o, .mem_data_oe_o);
`default_nettype wire

// ### dv/tb.sv
// Testbench for the static RAM host controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic mclk_i = 1'b0, reset_n_i = 1'b0, req_i = 1'b0, wr_i = 1'b0;
   logic [18:0] addr_i = 19'h0;
   logic [7:0] wdata_i = 8'h0;
   logic ready_o, rvalid_o, mem_sel_n_o, mem_wr_n_o, mem_oe_n_o, mem_data_oe_o, m_oe;
   logic [18:0] mem_addr_o;
   logic [7:0] rdata_o, mem_data_o, m_dq, rd;
   wire logic [7:0] mem_data_i = mem_data_oe_o ? mem_data_o : m_dq;
   int err_count = 0, samples_checked = 0;
   logic ready_f, rvalid_f, sel_n_f, wr_n_f, oe_n_f, data_oe_f, oe_f;
   logic [18:0] addr_f;
   logic [7:0] rdata_f, data_f, dq_f, rd_f;
   wire logic [7:0] data_in_f = data_oe_f ? data_f : dq_f;
   sram_host_ctrl dut (.mclk_i, .reset_n_i, .req_i, .wr_i, .addr_i, .wdata_i, .ready_o, .rvalid_o, .rdata_o,
      .mem_addr_o, .mem_sel_n_o, .mem_wr_n_o, .mem_oe_n_o, .mem_data_o, .mem_data_oe_o, .mem_data_i);
   sram_model ram (.addr_i(mem_addr_o), .sel_n_i(mem_sel_n_o), .wr_n_i(mem_wr_n_o), .oe_n_i(mem_oe_n_o),
      .dq_i(mem_data_i), .dq_o(m_dq), .dq_oe_o(m_oe));
   sram_host_ctrl #(.FAST_GRADE(1'b1)) dut_fast (.mclk_i, .reset_n_i, .req_i, .wr_i, .addr_i, .wdata_i,
      .ready_o(ready_f), .rvalid_o(rvalid_f), .rdata_o(rdata_f), .mem_addr_o(addr_f), .mem_sel_n_o(sel_n_f),
      .mem_wr_n_o(wr_n_f), .mem_oe_n_o(oe_n_f), .mem_data_o(data_f), .mem_data_oe_o(data_oe_f),
      .mem_data_i(data_in_f));
   sram_model #(.ACC_NS(70)) ram_fast (.addr_i(addr_f), .sel_n_i(sel_n_f), .wr_n_i(wr_n_f), .oe_n_i(oe_n_f),
      .dq_i(data_in_f), .dq_o(dq_f), .dq_oe_o(oe_f));
   initial forever #2 mclk_i = ~mclk_i;
   always @(negedge mclk_i) begin
      if (m_oe === 1'b1) chk({18'h0, mem_data_oe_o}, 19'h00000);
      if (oe_f === 1'b1) chk({18'h0, data_oe_f}, 19'h00000);
   end
   // ==========================================
   // Shared tasks
   task automatic chk(input logic [18:0] got, input logic [18:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] e);
      chk({11'h0, rd}, {11'h0, e});
      chk({11'h0, rd_f}, {11'h0, e});
   endtask
   task automatic op(input logic w, input logic [18:0] a, input logic [7:0] d, input logic poke);
      int n;
      n = 0;
      rd = 8'hzz;
      rd_f = 8'hzz;
      @(posedge mclk_i);
      #1 req_i = 1'b1;
      wr_i = w;
      addr_i = a;
      wdata_i = d;
      while ((ready_o !== 1'b1 || ready_f !== 1'b1) && n < 100) begin
         @(posedge mclk_i);
         #1 n++;
      end
      @(posedge mclk_i);
      #1 req_i = poke;
      addr_i = ~a;
      wr_i = 1'b0;
      repeat (5) @(posedge mclk_i);
      #1 req_i = 1'b0;
      chk(mem_addr_o, a);
      chk(addr_f, a);
      while (ready_o !== 1'b1 && n < 200) begin
         @(posedge mclk_i);
         #1 n++;
         if (rvalid_o === 1'b1) rd = rdata_o;
         if (rvalid_f === 1'b1) rd_f = rdata_f;
      end
      chk({18'h0, ready_o}, 19'h00001);
   endtask
   task automatic end_of_test;
      if (err_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic sc_reset;
      chk({14'h0, ready_o, mem_sel_n_o, mem_wr_n_o, mem_oe_n_o, mem_data_oe_o}, 19'h0000e);
      chk({14'h0, ready_f, sel_n_f, wr_n_f, oe_n_f, data_oe_f}, 19'h0000e);
   endtask
   task automatic sc_edges;
      op(1'b1, 19'h00000, 8'ha5, 1'b0);
      op(1'b1, 19'h7ffff, 8'h3c, 1'b0);
      op(1'b0, 19'h00000, 8'h00, 1'b0);
      rchk(8'ha5);
      op(1'b0, 19'h7ffff, 8'h00, 1'b0);
      rchk(8'h3c);
      chk({17'h0, ready_o, mem_sel_n_o}, 19'h00003);
      chk({17'h0, ready_f, sel_n_f}, 19'h00003);
   endtask
   task automatic sc_overwrite;
      op(1'b1, 19'h12345, 8'h11, 1'b0);
      op(1'b1, 19'h12345, 8'hee, 1'b0);
      op(1'b0, 19'h12345, 8'h00, 1'b0);
      rchk(8'hee);
   endtask
   task automatic sc_refused;
      op(1'b1, 19'h00abc, 8'h5a, 1'b1);
      op(1'b0, 19'h00abc, 8'h00, 1'b0);
      rchk(8'h5a);
      op(1'b0, 19'h54321, 8'h00, 1'b0);
      rchk(8'hxx);
   endtask
   // ==========================================
   // Main sequence and watchdog
   initial begin
      repeat (8) @(posedge mclk_i);
      sc_reset();
      #1 reset_n_i = 1'b1;
      sc_edges();
      sc_overwrite();
      sc_refused();
      end_of_test();
   end
   initial begin
      #20000;
      err_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
